//--- hw/ihc_pkg.sv
// package: register map, field layout and timing constants of the irq hold-off block
package ihc_pkg;
   // register offsets on the device register port
   localparam logic [7:0] IHC_OFS_CFG      = 8'h54;
   localparam logic [7:0] IHC_OFS_STATUS   = 8'h58;
   // interrupt_output_config field positions
   localparam int         IHC_CFG_INTV_LSB = 24;
   localparam int         IHC_CFG_RESTART  = 14;
   localparam int         IHC_CFG_ACTIVE   = 13;
   localparam int         IHC_CFG_MASTER   = 12;
   localparam int         IHC_CFG_ENABLE   = 8;
   localparam int         IHC_CFG_POL      = 4;
   localparam int         IHC_CFG_TYPE     = 0;
   // interrupt_status bit of the power event source
   localparam int         IHC_PWR_EVT_BIT  = 17;
   // reset values
   localparam logic [31:0] IHC_STATUS_RST  = 32'h0000_0000;
   localparam logic [7:0]  IHC_INTV_RST    = 8'h00;
   // hold-off step timing
   localparam int         IHC_CLK_MHZ      = 100;
   localparam int         IHC_STEP_US      = 10;
   localparam int         IHC_STEP_CYCLES  = IHC_STEP_US * IHC_CLK_MHZ;
   localparam logic [9:0] IHC_STEP_LAST    = 10'(IHC_STEP_CYCLES - 1);
   localparam logic [9:0] IHC_TICK_RST     = 10'h000;

   // software-writable configuration fields
   typedef struct packed {
      logic [7:0] interval;   // hold-off length in steps
      logic       irqEnable;  // pin enable
      logic       polarity;   // 1 = active high
      logic       bufType;    // 1 = push-pull, 0 = open drain
   } ihc_cfg_t;

   // one register port request
   typedef struct packed {
      logic        sel;       // access this cycle
      logic        write;     // 1 = write, 0 = read
      logic [7:0]  addr;      // byte offset
      logic [31:0] wdata;     // write data
   } ihc_reg_req_t;

   localparam ihc_cfg_t IHC_CFG_RST = '{interval: 8'h00, irqEnable: 1'b0,
                                        polarity: 1'b0, bufType: 1'b0};
endpackage

//--- hw/ihc_top.sv
// module: host interrupt pin conditioning with hold-off interval and status acknowledge
// Functional notes
// R1 - interval equals field value times ten microseconds
// R2 - withhold pin during interval, deliver otherwise
// R3 - zero interval disables, resets, issues pending
// R4 - new nonzero interval applies to later interrupts
// R5 - power event interrupt bypasses the interval
// R6 - restart bit clears counter, begins fresh interval
// R7 - status bit shows interval active, resets zero
// R8 - master bit mirrors internal interrupt line
// R9 - enable clear keeps pin deasserted always
// R10 - polarity zero active low, one active high
// R11 - buffer bit selects open drain or push-pull
// R12 - open drain ignores polarity, asserts low
// R13 - writing one clears status bit, zero keeps
// R14 - interval starts when pin assertion ends
// R15 - pending line asserts pin when interval expires
`timescale 1ns/1ps
`default_nettype none
module ihc_top (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // register port
   input  wire ihc_pkg::ihc_reg_req_t regReq,
   output var  logic [31:0]           regRdData_r,
   output var  logic                  regAck_r,
   // interrupt sources
   input  wire logic [31:0]           srcEvent,
   input  wire logic [31:0]           srcEnable,
   // interrupt pin
   output var  logic                  irqOut_r,
   output var  logic                  irqOeN_r
);
   import ihc_pkg::*;

   ihc_cfg_t    cfg_r;          // configuration fields
   logic [31:0] status_r;       // sticky interrupt status
   logic        holdoffActive_r; // interval running
   logic [9:0]  tickCnt_r;      // cycles within one step
   logic [7:0]  stepCnt_r;      // steps elapsed
   logic        asserted_r;     // logical pin assertion
   logic        cfgWrite;       // config write this cycle
   logic        statusWrite;    // status write this cycle
   logic        regRead;        // read this cycle
   logic        restartReq;     // restart command
   logic        zeroWrite;      // interval written with zero
   logic [7:0]  newInterval;    // written interval value
   logic        irqLine;        // internal master line
   logic        pmeLine;        // power event source active
   logic        assertReq;      // pin should assert
   logic        startInterval;  // assertion just ended
   logic        stepDone;       // one step elapsed
   logic        intervalDone;   // last step elapsed

   // access decode
   assign cfgWrite    = regReq.sel && regReq.write && (regReq.addr == IHC_OFS_CFG);
   assign statusWrite = regReq.sel && regReq.write && (regReq.addr == IHC_OFS_STATUS);
   assign regRead     = regReq.sel && !regReq.write;
   assign newInterval = regReq.wdata[IHC_CFG_INTV_LSB +: 8];
   assign restartReq  = cfgWrite && regReq.wdata[IHC_CFG_RESTART];
   assign zeroWrite   = cfgWrite && (newInterval == 8'h00);

   // internal lines
   assign irqLine = |(status_r & srcEnable); // R8
   assign pmeLine = status_r[IHC_PWR_EVT_BIT] && srcEnable[IHC_PWR_EVT_BIT];
   // assertion request: held off except for power event
   assign assertReq = cfg_r.irqEnable && ((irqLine && !holdoffActive_r) || pmeLine); // R2 R5 R9 R15
   assign startInterval = asserted_r && !assertReq; // R14
   assign stepDone      = holdoffActive_r && (tickCnt_r == IHC_STEP_LAST);
   assign intervalDone  = stepDone && ((stepCnt_r + 8'h01) >= cfg_r.interval); // R1 R4

   // configuration register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_r <= IHC_CFG_RST;
      end else if (cfgWrite) begin
         cfg_r.interval  <= newInterval;
         cfg_r.irqEnable <= regReq.wdata[IHC_CFG_ENABLE];
         cfg_r.polarity  <= regReq.wdata[IHC_CFG_POL];
         cfg_r.bufType   <= regReq.wdata[IHC_CFG_TYPE];
      end
   end

   // sticky status, a new event wins over an acknowledge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         status_r <= IHC_STATUS_RST;
      end else begin
         // write one clears, zero keeps
         status_r <= (status_r & ~(statusWrite ? regReq.wdata : 32'h0000_0000)) | srcEvent; // R13
      end
   end

   // hold-off interval state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         holdoffActive_r <= 1'b0;
      end else if (zeroWrite) begin
         // disable and release pending interrupts
         holdoffActive_r <= 1'b0; // R3
      end else if (restartReq || (startInterval && cfg_r.interval != 8'h00)) begin
         holdoffActive_r <= 1'b1; // R6 R14
      end else if (intervalDone) begin
         holdoffActive_r <= 1'b0; // R15
      end
   end

   // step and tick counters
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tickCnt_r <= IHC_TICK_RST;
         stepCnt_r <= 8'h00;
      end else if (zeroWrite || restartReq || startInterval || !holdoffActive_r) begin
         // fresh interval starts from zero
         tickCnt_r <= IHC_TICK_RST; // R3 R6
         stepCnt_r <= 8'h00;
      end else if (stepDone) begin
         tickCnt_r <= IHC_TICK_RST; // R1
         stepCnt_r <= stepCnt_r + 8'h01;
      end else begin
         tickCnt_r <= tickCnt_r + 10'h001;
      end
   end

   // pin drive, registered
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         asserted_r <= 1'b0;
         irqOut_r   <= 1'b0;
         irqOeN_r   <= 1'b1;
      end else begin
         asserted_r <= assertReq;
         if (cfg_r.bufType) begin
            // push-pull, polarity selects level
            irqOut_r <= assertReq ? cfg_r.polarity : !cfg_r.polarity; // R10 R11
            irqOeN_r <= 1'b0;
         end else begin
            // open drain, pull low only when asserted
            irqOut_r <= 1'b0; // R11 R12
            irqOeN_r <= !assertReq;
         end
      end
   end

   // read data and acknowledge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         regRdData_r <= 32'h0000_0000;
         regAck_r    <= 1'b0;
      end else begin
         regAck_r <= regReq.sel;
         if (regRead && regReq.addr == IHC_OFS_CFG) begin
            regRdData_r <= {cfg_r.interval, 10'h000, holdoffActive_r, irqLine,
                            3'h0, cfg_r.irqEnable, 3'h0, cfg_r.polarity,
                            3'h0, cfg_r.bufType}; // R7 R8
         end else if (regRead && regReq.addr == IHC_OFS_STATUS) begin
            regRdData_r <= status_r;
         end else begin
            // unmapped and writes read zero
            regRdData_r <= 32'h0000_0000;
         end
      end
   end

   // helper: cycles spent in the current interval
   logic [19:0] activeCycles_r;
   // cleared on the events that also clear the step counters except a zero write (cleared one cycle later), else a
   // re-started interval would be charged with the cycles of the old one
   always_ff @(posedge clk_sys) begin
      if (rst || !holdoffActive_r || restartReq || startInterval) begin
         activeCycles_r <= 20'h00000;
      end else begin
         activeCycles_r <= activeCycles_r + 20'h00001;
      end
   end

   // interval never outlasts field times step length
   property p_intervalLen;
      @(posedge clk_sys) disable iff (rst)
      holdoffActive_r |-> (activeCycles_r < 20'(cfg_r.interval) * 20'(IHC_STEP_CYCLES));
   endproperty
   a_intervalLen: assert property (p_intervalLen) else $error("interval too long"); // R1

   // no delivery while held off
   property p_withhold;
      @(posedge clk_sys) disable iff (rst)
      (holdoffActive_r && !pmeLine) |=> !asserted_r;
   endproperty
   a_withhold: assert property (p_withhold) else $error("pin asserted in hold-off"); // R2

   // zero write ends the interval
   property p_zeroWrite;
      @(posedge clk_sys) disable iff (rst)
      zeroWrite |=> !holdoffActive_r ##1 (asserted_r == $past(cfg_r.irqEnable && irqLine));
   endproperty
   a_zeroWrite: assert property (p_zeroWrite) else $error("zero interval not released"); // R3

   // power event not delayed
   property p_pmeBypass;
      @(posedge clk_sys) disable iff (rst)
      (pmeLine && cfg_r.irqEnable) |=> asserted_r;
   endproperty
   a_pmeBypass: assert property (p_pmeBypass) else $error("power event delayed"); // R5

   // restart begins a fresh interval
   property p_restart;
      @(posedge clk_sys) disable iff (rst)
      (restartReq && !zeroWrite) |=> (holdoffActive_r && tickCnt_r == IHC_TICK_RST
                                       && stepCnt_r == 8'h00);
   endproperty
   a_restart: assert property (p_restart) else $error("restart not fresh"); // R6

   // status bit follows interval state
   property p_statusRead;
      @(posedge clk_sys) disable iff (rst)
      (regRead && regReq.addr == IHC_OFS_CFG) |=>
         (regRdData_r[IHC_CFG_ACTIVE] == $past(holdoffActive_r)
          && regRdData_r[IHC_CFG_MASTER] == $past(irqLine));
   endproperty
   a_statusRead: assert property (p_statusRead) else $error("config readback wrong"); // R7

   // disabled pin stays deasserted
   property p_disabled;
      @(posedge clk_sys) disable iff (rst)
      !cfg_r.irqEnable |=> (!asserted_r && (irqOeN_r || irqOut_r != $past(cfg_r.polarity)));
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled pin asserted"); // R9

   // open drain only ever pulls low
   property p_openDrain;
      @(posedge clk_sys) disable iff (rst)
      !cfg_r.bufType |=> (irqOut_r == 1'b0 && irqOeN_r == !$past(assertReq));
   endproperty
   a_openDrain: assert property (p_openDrain) else $error("open drain misdriven"); // R12

   // acknowledge clears the written bit
   property p_ack;
      @(posedge clk_sys) disable iff (rst)
      (statusWrite && regReq.wdata[0] && !srcEvent[0]) |=> !status_r[0];
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge did not clear"); // R13

   // end of assertion starts the interval
   property p_startHold;
      @(posedge clk_sys) disable iff (rst)
      (startInterval && cfg_r.interval != 8'h00 && !cfgWrite) |=> holdoffActive_r;
   endproperty
   a_startHold: assert property (p_startHold) else $error("interval did not start"); // R14
endmodule
`default_nettype wire

//--- bench/ihc_host_model.sv
// host side of the interrupt pin: resolves the shared wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ihc_host_model (
   // pin as driven by the device
   input  wire logic irqOut_r,
   input  wire logic irqOeN_r,
   // resolved wire level seen by the host
   output var  logic hostPin
);
   // released wire floats to the pull-up level, wired-or friendly
   always_comb hostPin = irqOeN_r ? 1'b1 : irqOut_r;
endmodule
`default_nettype wire

//--- bench/irq_output_holdoff_control_tb.sv
// testbench: pin modes, acknowledge, hold-off timing and bypass of the hold-off block
`timescale 1ns/1ps
`default_nettype none
module irq_output_holdoff_control_tb;
   import ihc_pkg::*;
   logic                clk_sys;     // system clock
   logic                rst;         // sync reset
   ihc_reg_req_t        req;         // register request
   logic [31:0]         rdData;      // read data
   logic                ack;         // register ack
   logic [31:0]         srcEvent;    // source events
   logic [31:0]         srcEnable;   // source enables
   logic                irqOut;      // pin data
   logic                irqOeN;      // pin enable, low drives
   logic                hostPin;     // resolved wire
   logic [31:0]         rdVal;       // last read value
   int                  errCount;    // mismatches
   int                  nCompared;   // comparisons
   int                  cycles;      // timeout counter
   // pin mode rows: config word and {out, oeN, wire}
   logic [31:0]         cfgRow [5] = '{32'h0, 32'h100, 32'h110, 32'h101, 32'h111};
   logic [2:0]          expRow [5] = '{3'h3, 3'h0, 3'h0, 3'h0, 3'h5};

   ihc_top uut (.clk_sys(clk_sys), .rst(rst), .regReq(req), .regRdData_r(rdData),
                .regAck_r(ack), .srcEvent(srcEvent), .srcEnable(srcEnable),
                .irqOut_r(irqOut), .irqOeN_r(irqOeN));
   ihc_host_model host (.irqOut_r(irqOut), .irqOeN_r(irqOeN), .hostPin(hostPin));

   // clock generator
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errCount = errCount + 1;
         give_verdict();
      end
   end
   // compare seen against expected
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared = nCompared + 1;
      if (seen !== exp) begin
         errCount = errCount + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one register access, answer one cycle later
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(negedge clk_sys);
      req = '{sel: 1'b1, write: wr, addr: a, wdata: d};
      @(negedge clk_sys);
      req.sel = 1'b0;
      rdVal = rdData;
      chk({31'h0, ack}, 32'h1);
   endtask
   // one-cycle event pulse on a source
   task automatic pulse(input int b);
      @(negedge clk_sys);
      srcEvent[b] = 1'b1;
      @(negedge clk_sys);
      srcEvent = 32'h0;
   endtask
   // bounded wait for the pin to assert
   task automatic waitPin(input int lim);
      int k;
      for (k = 0; k < lim && irqOut !== 1'b1; k++) @(negedge clk_sys);
      chk({31'h0, irqOut}, 32'h1);
   endtask
   // idle cycles
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // closing report
   task automatic give_verdict();
      if (errCount == 0 && nCompared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      req = '0;
      srcEvent = 32'h0;
      srcEnable = 32'h0002_0001;
      errCount = 0;
      nCompared = 0;
      cycles = 0;
      idle(12);
      rst = 1'b0;
      acc(1'b0, IHC_OFS_CFG, 32'h0);
      chk(rdVal, 32'h0);
      acc(1'b0, IHC_OFS_STATUS, 32'h0);
      chk(rdVal, IHC_STATUS_RST);
      pulse(0);
      // pin modes, one row each
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, IHC_OFS_CFG, cfgRow[i]);
         idle(1);
         chk({30'h0, irqOut, irqOeN}, {30'h0, expRow[i][2:1]});
         chk({31'h0, hostPin}, {31'h0, expRow[i][0]});
         acc(1'b0, IHC_OFS_CFG, 32'h0);
         chk(rdVal, cfgRow[i] | 32'h1000);
      end
      // acknowledge: zero keeps, one clears
      acc(1'b1, IHC_OFS_STATUS, 32'h0);
      acc(1'b0, IHC_OFS_STATUS, 32'h0);
      chk(rdVal, 32'h1);
      acc(1'b1, IHC_OFS_STATUS, 32'h1);
      acc(1'b0, IHC_OFS_STATUS, 32'h0);
      chk(rdVal, 32'h0);
      // hold-off of one step after the pin drops
      acc(1'b1, IHC_OFS_CFG, 32'h0100_0111);
      pulse(0);
      idle(2);
      chk({31'h0, irqOut}, 32'h1);
      acc(1'b1, IHC_OFS_STATUS, 32'h1);
      idle(2);
      acc(1'b0, IHC_OFS_CFG, 32'h0);
      chk(rdVal, 32'h0100_2111);
      pulse(0);
      idle(900);
      chk({31'h0, irqOut}, 32'h0);
      waitPin(150);
      // power event passes a running hold-off
      acc(1'b1, IHC_OFS_STATUS, 32'h1);
      idle(3);
      pulse(IHC_PWR_EVT_BIT);
      idle(2);
      chk({31'h0, irqOut}, 32'h1);
      acc(1'b1, IHC_OFS_STATUS, 32'h0002_0000);
      idle(2);
      // restart, then zero interval releases the pending line
      acc(1'b1, IHC_OFS_CFG, 32'h0100_4111);
      acc(1'b0, IHC_OFS_CFG, 32'h0);
      chk(rdVal, 32'h0100_2111);
      pulse(0);
      idle(2);
      chk({31'h0, irqOut}, 32'h0);
      acc(1'b1, IHC_OFS_CFG, 32'h0000_0111);
      idle(1);
      chk({31'h0, irqOut}, 32'h1);
      acc(1'b0, IHC_OFS_CFG, 32'h0);
      chk(rdVal, 32'h0000_1111);
      // longer interval applies to the next interrupt
      acc(1'b1, IHC_OFS_CFG, 32'h0200_0111);
      acc(1'b1, IHC_OFS_STATUS, 32'h1);
      pulse(0);
      idle(1900);
      chk({31'h0, irqOut}, 32'h0);
      waitPin(250);
      // restart from an idle hold-off starts a fresh interval
      acc(1'b1, IHC_OFS_CFG, 32'h0200_4111);
      acc(1'b0, IHC_OFS_CFG, 32'h0);
      chk(rdVal, 32'h0200_3111);
      chk({31'h0, irqOut}, 32'h0);
      // unmapped place reads zero
      acc(1'b1, 8'h60, 32'hFFFF_FFFF);
      acc(1'b0, 8'h60, 32'h0);
      chk(rdVal, 32'h0);
      // reset in mid-run while an interval is running
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      acc(1'b0, IHC_OFS_CFG, 32'h0);
      chk(rdVal, 32'h0);
      chk({30'h0, irqOut, irqOeN}, 32'h1);
      chk({31'h0, hostPin}, 32'h1);
      give_verdict();
   end
endmodule
`default_nettype wire
